// file: hw/wwdt_pkg.sv
// Purpose: Shared constants for the windowed watchdog timer block.
// Assumes: AXI4-Lite register access, 32-bit data, 100 MHz aclk.
// Notes:   Register offsets are byte addresses; one aligned word each.
// Operation
// - Watchdog comes up enabled and counting after every reset, no software arming.
// - Disable command stops it, enable command restarts it, accepted at any time.
// - Overflow without service raises a reset request to system reset logic.
// - Service while enabled and count is below the window boundary also raises reset request.
// - 16-bit counter, system or wake-up clock, prescaled by 16384 or 256.
// - Each valid service loads the counter with the programmed reload value.
// - Default settings give about 0.13 s timeout from the 500 kHz wake-up clock.
package wwdt_pkg;

    // ==========================================================
    // Register map
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_RELOAD = 8'h04;
    localparam logic [7:0] OFS_WINDOW = 8'h08;
    localparam logic [7:0] OFS_CMD = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_COUNT = 8'h14;

    // ==========================================================
    // Field positions
    localparam int unsigned CTRL_CLK_SEL_BIT = 0;
    localparam int unsigned CTRL_DIV_SEL_BIT = 1;
    localparam int unsigned CMD_SERVICE_BIT = 0;
    localparam int unsigned CMD_DISABLE_BIT = 1;
    localparam int unsigned CMD_ENABLE_BIT = 2;
    localparam int unsigned STAT_ENABLED_BIT = 0;
    localparam int unsigned STAT_RESET_REQ_BIT = 1;
    localparam int unsigned STAT_OVERFLOW_BIT = 2;
    localparam int unsigned STAT_EARLY_BIT = 3;

    // ==========================================================
    // Prescaler and default interval
    localparam int unsigned PRESCALE_W = 14;
    localparam int unsigned DIV_SLOW = 16384;
    localparam int unsigned DIV_FAST = 256;
    localparam int unsigned DEFAULT_INTERVAL_US = 130000;
    localparam int unsigned WAKEUP_FREQ_KHZ = 500;
    // Wake-up clock edges in the default interval, then whole prescaled ticks
    localparam int unsigned DEFAULT_EDGES = DEFAULT_INTERVAL_US * WAKEUP_FREQ_KHZ / 1000;
    localparam int unsigned DEFAULT_TICKS = (DEFAULT_EDGES + DIV_FAST - 1) / DIV_FAST;

    // ==========================================================
    // Reset values
    localparam logic RESET_CLK_SEL = 1'h1;
    localparam logic RESET_DIV_SEL = 1'h1;
    localparam logic [15:0] RESET_RELOAD = 16'(32'h0001_0000 - DEFAULT_TICKS);
    localparam logic [15:0] RESET_WINDOW = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;

    // ==========================================================
    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// file: hw/wwdt_prescaler.sv
// Purpose: Clock source selection and prescaler for the watchdog counter.
// Assumes: Wake-up clock is far slower than aclk; it is sampled as a level.
// Notes:   Emits a one-cycle tick every 16384 or 256 selected source edges.
module wwdt_prescaler (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Source and mode
    input wire logic wakeup_osc_clock,
    input wire logic clk_sel,
    input wire logic div_sel,
    // Control
    input wire logic run,
    input wire logic restart,
    // Result
    output logic tick
);

    // ==========================================================
    // State
    typedef struct packed {
        logic sync_a;
        logic sync_b;
        logic prev;
        logic [wwdt_pkg::PRESCALE_W-1:0] cnt;
        logic tick;
    } wwdt_presc_type;

    wwdt_presc_type s;
    wwdt_presc_type next_s;
    logic [wwdt_pkg::PRESCALE_W-1:0] last;
    logic step;

    // Terminal count for the chosen division
    assign last = div_sel ? wwdt_pkg::PRESCALE_W'(wwdt_pkg::DIV_FAST - 1)
                          : wwdt_pkg::PRESCALE_W'(wwdt_pkg::DIV_SLOW - 1);
    // Rising wake-up edge, or every aclk cycle for the system clock
    assign step = clk_sel ? (s.sync_b & ~s.prev) : 1'b1;
    assign tick = s.tick;

    // Next state; restart keeps a fresh service from landing mid-tick
    always_comb
    begin
        next_s = s;
        next_s.sync_a = wakeup_osc_clock;
        next_s.sync_b = s.sync_a;
        next_s.prev = s.sync_b;
        next_s.tick = 1'b0;
        if (restart || !run)
        begin
            next_s.cnt = '0;
        end
        else if (step)
        begin
            if (s.cnt == last)
            begin
                next_s.cnt = '0;
                next_s.tick = 1'b1;
            end
            else
            begin
                next_s.cnt = s.cnt + 1'b1;
            end
        end
    end

    // Register
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            s <= '0;
        else
            s <= next_s;
    end

    // ==========================================================
    // Checks
    chk_tick_spacing: assert property (@(posedge aclk) disable iff (!aresetn)
        s.tick |=> !s.tick [*8])
        else $error("prescaler ticks closer than the division allows");

endmodule // wwdt_prescaler

// file: hw/wwdt_top.sv
// Purpose: Windowed watchdog timer with AXI4-Lite register access.
// Assumes: Single aclk domain; wake-up clock arrives as a plain pin.
// Notes:   Reset request is sticky until the system reset clears it.
module wwdt_top (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic [2:0] awprot,
    // AXI4-Lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // AXI4-Lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    input wire logic [2:0] arprot,
    // AXI4-Lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Watchdog clock source and reset request
    input wire logic wakeup_osc_clock,
    output logic reset_request
);

    // ==========================================================
    // State
    typedef struct packed {
        logic enabled;
        logic clk_sel;
        logic div_sel;
        logic [15:0] reload;
        logic [15:0] window;
        logic [15:0] count;
        logic rst_req;
        logic cause_ovf;
        logic cause_early;
        logic aw_held;
        logic [7:0] aw_addr;
        logic w_held;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } wwdt_state_type;

    localparam wwdt_state_type RESET_STATE = '{
        enabled: 1'b1,
        clk_sel: wwdt_pkg::RESET_CLK_SEL,
        div_sel: wwdt_pkg::RESET_DIV_SEL,
        reload: wwdt_pkg::RESET_RELOAD,
        window: wwdt_pkg::RESET_WINDOW,
        count: wwdt_pkg::RESET_RELOAD,
        default: '0
    };

    wwdt_state_type s;
    wwdt_state_type next_s;
    logic do_write;
    logic cmd_write;
    logic cmd_service;
    logic cmd_disable;
    logic cmd_enable;
    logic tick;
    logic early;
    logic wrap;

    // Merge a 16-bit field under the low two byte strobes
    function automatic logic [15:0] merge16(
        input logic [15:0] old,
        input logic [31:0] data,
        input logic [3:0] strb
    );
        logic [15:0] res;
        res = old;
        if (strb[0])
            res[7:0] = data[7:0];
        if (strb[1])
            res[15:8] = data[15:8];
        return res;
    endfunction

    // ==========================================================
    // Bus handshakes; one transfer of each kind in flight
    assign awready = !s.aw_held;
    assign wready = !s.w_held;
    assign arready = !s.rvalid;
    assign bvalid = s.bvalid;
    assign bresp = s.bresp;
    assign rvalid = s.rvalid;
    assign rdata = s.rdata;
    assign rresp = s.rresp;
    assign reset_request = s.rst_req;

    // Commands only come from byte 0 of a write to the command word
    assign do_write = s.aw_held && s.w_held && !s.bvalid;
    assign cmd_write = do_write && (s.aw_addr == wwdt_pkg::OFS_CMD) && s.wstrb[0];
    assign cmd_service = cmd_write && s.wdata[wwdt_pkg::CMD_SERVICE_BIT];
    assign cmd_disable = cmd_write && s.wdata[wwdt_pkg::CMD_DISABLE_BIT];
    assign cmd_enable = cmd_write && s.wdata[wwdt_pkg::CMD_ENABLE_BIT];

    // Window breach: service while still below the boundary
    assign early = cmd_service && s.enabled && (s.count < s.window);
    assign wrap = s.enabled && tick && (s.count == wwdt_pkg::COUNT_MAX);

    // ==========================================================
    // Prescaler; a service restarts it so the reload gets a full first tick
    wwdt_prescaler u_presc (
        .aclk(aclk),
        .aresetn(aresetn),
        .wakeup_osc_clock(wakeup_osc_clock),
        .clk_sel(s.clk_sel),
        .div_sel(s.div_sel),
        .run(s.enabled),
        .restart(cmd_service),
        .tick(tick)
    );

    // ==========================================================
    // Next state: bus, registers, counter
    always_comb
    begin
        next_s = s;
        // Response channels drop once taken
        if (s.bvalid && bready)
            next_s.bvalid = 1'b0;
        if (s.rvalid && rready)
            next_s.rvalid = 1'b0;
        // Address and data are latched independently, in either order
        if (awvalid && !s.aw_held)
        begin
            next_s.aw_held = 1'b1;
            next_s.aw_addr = awaddr;
        end
        if (wvalid && !s.w_held)
        begin
            next_s.w_held = 1'b1;
            next_s.wdata = wdata;
            next_s.wstrb = wstrb;
        end
        // Register write once both halves are here
        if (do_write)
        begin
            next_s.aw_held = 1'b0;
            next_s.w_held = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = wwdt_pkg::RESP_OKAY;
            case (s.aw_addr)
                wwdt_pkg::OFS_CTRL:
                begin
                    if (s.wstrb[0])
                    begin
                        next_s.clk_sel = s.wdata[wwdt_pkg::CTRL_CLK_SEL_BIT];
                        next_s.div_sel = s.wdata[wwdt_pkg::CTRL_DIV_SEL_BIT];
                    end
                end
                wwdt_pkg::OFS_RELOAD:
                    next_s.reload = merge16(s.reload, s.wdata, s.wstrb);
                wwdt_pkg::OFS_WINDOW:
                    next_s.window = merge16(s.window, s.wdata, s.wstrb);
                wwdt_pkg::OFS_CMD, wwdt_pkg::OFS_STATUS, wwdt_pkg::OFS_COUNT:
                    next_s.bresp = wwdt_pkg::RESP_OKAY;
                default:
                    next_s.bresp = wwdt_pkg::RESP_SLVERR;
            endcase
        end
        // Read: data registered one cycle after the address is taken
        if (arvalid && !s.rvalid)
        begin
            next_s.rvalid = 1'b1;
            next_s.rresp = wwdt_pkg::RESP_OKAY;
            next_s.rdata = '0;
            case (araddr)
                wwdt_pkg::OFS_CTRL:
                begin
                    next_s.rdata[wwdt_pkg::CTRL_CLK_SEL_BIT] = s.clk_sel;
                    next_s.rdata[wwdt_pkg::CTRL_DIV_SEL_BIT] = s.div_sel;
                end
                wwdt_pkg::OFS_RELOAD:
                    next_s.rdata[15:0] = s.reload;
                wwdt_pkg::OFS_WINDOW:
                    next_s.rdata[15:0] = s.window;
                wwdt_pkg::OFS_CMD:
                    next_s.rdata = '0;
                wwdt_pkg::OFS_STATUS:
                begin
                    next_s.rdata[wwdt_pkg::STAT_ENABLED_BIT] = s.enabled;
                    next_s.rdata[wwdt_pkg::STAT_RESET_REQ_BIT] = s.rst_req;
                    next_s.rdata[wwdt_pkg::STAT_OVERFLOW_BIT] = s.cause_ovf;
                    next_s.rdata[wwdt_pkg::STAT_EARLY_BIT] = s.cause_early;
                end
                wwdt_pkg::OFS_COUNT:
                    next_s.rdata[15:0] = s.count;
                default:
                    next_s.rresp = wwdt_pkg::RESP_SLVERR;
            endcase
        end
        // Enable beats disable when both bits arrive in one write
        if (cmd_disable)
            next_s.enabled = 1'b0;
        if (cmd_enable)
            next_s.enabled = 1'b1;
        // Counter: service reload has priority over a coincident tick
        if (cmd_service)
            next_s.count = s.reload;
        else if (s.enabled && tick)
            next_s.count = s.count + 16'h0001;
        // Causes are sticky; only a system reset lets go of the request
        if (wrap && !cmd_service)
        begin
            next_s.rst_req = 1'b1;
            next_s.cause_ovf = 1'b1;
        end
        if (early)
        begin
            next_s.rst_req = 1'b1;
            next_s.cause_early = 1'b1;
        end
    end

    // Register; reset brings the watchdog up armed with default interval
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            s <= RESET_STATE;
        else
            s <= next_s;
    end

    // ==========================================================
    // Checks
    chk_armed_after_reset: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(aresetn) |-> s.enabled && !s.rst_req && s.count == s.reload)
        else $error("watchdog not armed after reset");

    chk_default_setup: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(aresetn) |-> s.clk_sel && s.div_sel && s.reload == wwdt_pkg::RESET_RELOAD)
        else $error("default timeout settings wrong after reset");

    chk_disable_enable: assert property (@(posedge aclk) disable iff (!aresetn)
        cmd_write |=> s.enabled == ($past(cmd_enable) || ($past(s.enabled) && !$past(cmd_disable))))
        else $error("enable or disable command not obeyed");

    chk_halt_when_off: assert property (@(posedge aclk) disable iff (!aresetn)
        (!s.enabled && !cmd_service) |=> $stable(s.count))
        else $error("counter moved while disabled");

    chk_overflow_reset: assert property (@(posedge aclk) disable iff (!aresetn)
        (wrap && !cmd_service) |=> reset_request && s.cause_ovf && s.count == 16'h0000)
        else $error("overflow did not raise reset request");

    chk_early_service: assert property (@(posedge aclk) disable iff (!aresetn)
        early |=> reset_request && s.cause_early)
        else $error("service inside window did not raise reset request");

    chk_request_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
        reset_request |=> reset_request [*4])
        else $error("reset request dropped before system reset");

    chk_service_reload: assert property (@(posedge aclk) disable iff (!aresetn)
        cmd_service |=> s.count == $past(s.reload))
        else $error("service did not load reload value");

    chk_count_step: assert property (@(posedge aclk) disable iff (!aresetn)
        (s.enabled && tick && !cmd_service) |=> s.count == 16'($past(s.count) + 16'h0001))
        else $error("counter did not step on prescaled tick");

    chk_no_false_reset: assert property (@(posedge aclk) disable iff (!aresetn)
        (!reset_request && !wrap && !early) |=> !reset_request)
        else $error("reset request without cause");

    chk_late_service: assert property (@(posedge aclk) disable iff (!aresetn)
        (cmd_service && !early && !wrap && !reset_request) |=> !reset_request)
        else $error("service outside window raised reset request");

    chk_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
        do_write |=> bvalid)
        else $error("write response missing after register write");

    chk_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
        (arvalid && arready) |=> rvalid)
        else $error("read data missing after address taken");

    chk_bresp_taken: assert property (@(posedge aclk) disable iff (!aresetn)
        (bvalid && bready) |=> !bvalid)
        else $error("write response stayed after it was taken");

    chk_rresp_taken: assert property (@(posedge aclk) disable iff (!aresetn)
        (rvalid && rready) |=> !rvalid)
        else $error("read data stayed after it was taken");

endmodule // wwdt_top

// file: bench/wwdt_wakeup_osc.sv
// Purpose: Far-side wake-up oscillator feeding the watchdog clock pin.
// Assumes: Runs only while the bench asks for it; otherwise held low.
// Notes:   Period of 40 ns keeps it well below aclk for the sync flops.
module wwdt_wakeup_osc #(
    parameter int HALF_NS = 20
) (
    // Control
    input wire logic run,
    // Clock pin
    output logic osc
);
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // Free oscillation only while enabled, parked low otherwise; one process drives it
    initial
    begin
        osc = 1'b0;
        forever
        begin
            #(HALF_NS);
            osc = run ? ~osc : 1'b0;
        end
    end
endmodule // wwdt_wakeup_osc

// file: bench/wwdt_tb.sv
// Purpose: Self-checking bench for the windowed watchdog over AXI4-Lite.
// Assumes: bready and rready held high; master waits for every answer.
// Notes:   Expected values come from an integer model of the registers.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // Signals and model
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
    logic arvalid = 1'b0, bready = 1'b1, rready = 1'b1, osc_run = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000, rdata, rv;
    logic [3:0] wstrb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid, reset_request, wk;
    logic [1:0] bresp, rresp, rs;
    int n_fail = 0, checks = 0, cyc = 0, seed = 32'hf5fc, v, i;
    int mdl[int];
    int en_b = 1 << wwdt_pkg::STAT_ENABLED_BIT;
    int rq_b = 1 << wwdt_pkg::STAT_RESET_REQ_BIT;

    always #5 aclk = ~aclk;

    wwdt_wakeup_osc osc_u (.run(osc_run), .osc(wk));

    wwdt_top dut_u (
        .aclk(aclk), .aresetn(aresetn),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .wakeup_osc_clock(wk), .reset_request(reset_request)
    );

    // ==========================================================
    // Closing report and hang guard
    task automatic wrap_up();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 70000)
        begin
            n_fail = n_fail + 1;
            wrap_up();
        end
    end

    // ==========================================================
    // Compare, bus cycles and reset
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        checks = checks + 1;
        if (g !== e)
        begin
            n_fail = n_fail + 1;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask

    // Address and data offered together, each dropped once taken
    task automatic wr(logic [7:0] a, logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        rs = bresp;
        if (a == wwdt_pkg::OFS_RELOAD || a == wwdt_pkg::OFS_WINDOW) mdl[a] = d & 32'hFFFF;
    endtask

    task automatic rd(logic [7:0] a, output logic [31:0] d);
        araddr <= a;
        arvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        rs = rresp;
    endtask

    task automatic rc(string n, logic [7:0] a, logic [31:0] e);
        rd(a, rv);
        chk(n, e, rv);
    endtask

    // Model reset: default interval rounded up to whole prescaled ticks
    task automatic do_reset();
        aresetn <= 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        mdl[0] = 3;
        mdl[4] = 32'h10000 - (130000 * 500 / 1000 + 255) / 256;
        mdl[8] = 0;
        mdl[12] = 0;
        mdl[16] = en_b;
        mdl[20] = mdl[4];
    endtask

    // Request must rise no sooner than lo and before hi cycles
    task automatic wait_req(int lo, int hi);
        for (i = 0; i < hi; i++)
        begin
            @(posedge aclk);
            if (reset_request === 1'b1) break;
        end
        chk("request timing", 1, i >= lo && i < hi);
    endtask

    // ==========================================================
    // Main sequence
    initial
    begin
        do_reset();
        foreach (mdl[a]) rc("reset value", a[7:0], mdl[a]);
        chk("request after reset", 0, reset_request);
        rc("unmapped read", 8'h18, 0);
        chk("unmapped rresp", wwdt_pkg::RESP_SLVERR, rs);
        wr(8'h18, 32'h5);
        chk("unmapped bresp", wwdt_pkg::RESP_SLVERR, rs);

        // Window boundary while count stands still (no wake-up edges)
        wr(wwdt_pkg::OFS_WINDOW, mdl[4]);
        wr(wwdt_pkg::OFS_CMD, 32'h1);
        repeat (3) @(posedge aclk);
        chk("service at boundary", 0, reset_request);
        // Random reloads, each service must load it
        for (int k = 0; k < 4; k++)
        begin
            v = ($random(seed) & 32'h7FFE) | 32'h8000; // Leaves room for v + 1 below
            wr(wwdt_pkg::OFS_WINDOW, 0);
            wr(wwdt_pkg::OFS_RELOAD, v);
            wr(wwdt_pkg::OFS_CMD, 32'h1);
            rc("count after service", wwdt_pkg::OFS_COUNT, v);
            rc("reload readback", wwdt_pkg::OFS_RELOAD, mdl[4]);
        end
        // One above the count: early service
        wr(wwdt_pkg::OFS_WINDOW, v + 1);
        wr(wwdt_pkg::OFS_CMD, 32'h1);
        wait_req(0, 4);
        rc("early cause", wwdt_pkg::OFS_STATUS, en_b | rq_b | 8);

        // Disable halts, enable continues (system clock /256)
        do_reset();
        wr(wwdt_pkg::OFS_CTRL, 32'h2);
        wr(wwdt_pkg::OFS_CMD, 32'h2);
        rc("disabled status", wwdt_pkg::OFS_STATUS, 0);
        rd(wwdt_pkg::OFS_COUNT, rv);
        v = rv;
        repeat (600) @(posedge aclk);
        rc("held count", wwdt_pkg::OFS_COUNT, v);
        wr(wwdt_pkg::OFS_CMD, 32'h4);
        repeat (600) @(posedge aclk);
        rc("resumed count", wwdt_pkg::OFS_COUNT, v + 2);
        wr(wwdt_pkg::OFS_CMD, 32'h6);
        rc("enable wins", wwdt_pkg::OFS_STATUS, en_b);

        // Timely services keep it quiet, then overflow fires on time
        do_reset();
        wr(wwdt_pkg::OFS_CTRL, 32'h2);
        wr(wwdt_pkg::OFS_RELOAD, 32'hFFF0);
        for (int k = 0; k < 3; k++)
        begin
            wr(wwdt_pkg::OFS_CMD, 32'h1);
            repeat (3500) @(posedge aclk);
        end
        chk("serviced request", 0, reset_request);
        wr(wwdt_pkg::OFS_CMD, 32'h1);
        wait_req(16 * 256 - 40, 16 * 256 + 40);
        rc("overflow cause", wwdt_pkg::OFS_STATUS, en_b | rq_b | 4);
        rd(wwdt_pkg::OFS_COUNT, rv);
        chk("wrapped count", 1, rv < 2);

        // Wake-up clock /256, then system clock /16384
        do_reset();
        osc_run <= 1'b1;
        repeat (2100) @(posedge aclk);
        rc("wake-up ticks", wwdt_pkg::OFS_COUNT, mdl[4] + 2);
        osc_run <= 1'b0;
        wr(wwdt_pkg::OFS_CTRL, 32'h0);
        wr(wwdt_pkg::OFS_CMD, 32'h1);
        repeat (16384 + 20) @(posedge aclk);
        rc("slow tick", wwdt_pkg::OFS_COUNT, mdl[4] + 1);
        wrap_up();
    end
endmodule // testbench
